// ### design/twm_master_rx.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - a master transfer only ever begins with a START on the bus.
// - address direction bit picks transmitter (write) or receiver (read) operation.
// - status codes read with the three prescaler bits as zero.
// - software starts with flag 1, start 1, stop 0, enable 1; enable 0 halts.
// - START waits until the bus is free, then is generated.
// - after START the flag sets and status reads 0x08.
// - writing one to the flag clears it and launches the next bus action.
// - after read address and acknowledge, flag sets with 0x38, 0x40 or 0x48.
// - each received byte is readable from data register once flag sets.
// - last byte gets not-acknowledge; software clears acknowledge-enable beforehand.
// - clear with stop only sends STOP, then hardware clears stop request.
// - clear with start only sends repeated START, status 0x10, bus kept.
// - at 0x10 a read address stays receiver, write address becomes transmitter.
// - lost arbitration gives 0x38; start 0 releases bus, start 1 retries when free.
// - at 0x40 next byte is received, acknowledged per acknowledge-enable.
// - at 0x48 start/stop give repeated START, STOP, or STOP then START.
// - at 0x50 clearing flag receives another byte, acknowledged per acknowledge-enable.
// - at 0x58 start/stop give repeated START, STOP, or STOP then START.
module twm_master_rx
  import twm_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire twm_apb_req_t apb_req,
  output twm_apb_rsp_t      apb_rsp,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output twm_pins_t         bus_pins
);

  twm_state_t st_r;
  twm_state_t st_nxt;

  assign apb_rsp  = st_r.rsp;
  assign bus_pins = st_r.pins;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic [7:0]  ctrl_byte;
    logic        acc;
    logic        wr_ctrl;
    logic        wr_data;
    logic        go;
    logic        s;
    logic        tx;
    logic        lost;
    w         = apb_req.pwdata;
    ctrl_byte = 8'h00;
    acc       = apb_req.psel & apb_req.penable & st_r.rsp.pready;
    wr_ctrl   = acc & apb_req.pwrite & (apb_req.paddr == TWM_CTRL_OFS);
    wr_data   = acc & apb_req.pwrite & (apb_req.paddr == TWM_DATA_OFS);
    go        = 1'b0;
    s         = st_r.sda_sy[1];
    tx        = st_r.addr_phase | st_r.tx_mode;
    lost      = 1'b0;
    st_nxt    = st_r;

    // pin synchronisers and bus-busy watch (start/stop seen by anyone)
    st_nxt.sda_sy = {st_r.sda_sy[0], sda_in};
    st_nxt.scl_sy = {st_r.scl_sy[0], scl_in};
    st_nxt.sda_q  = st_r.sda_sy[1];
    st_nxt.scl_q  = st_r.scl_sy[1];
    if (st_r.scl_sy[1] && st_r.scl_q) begin
      if (st_r.sda_q && !st_r.sda_sy[1]) begin
        st_nxt.busy = 1'b1;
      end else if (!st_r.sda_q && st_r.sda_sy[1]) begin
        st_nxt.busy = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait state, write lands on the pready edge
    // ----------------------------------------------------------------
    ctrl_byte[TWM_FLAG_BIT] = st_r.flag;
    ctrl_byte[TWM_ACK_BIT]  = st_r.ack_en;
    ctrl_byte[TWM_STA_BIT]  = st_r.sta;
    ctrl_byte[TWM_STO_BIT]  = st_r.sto;
    ctrl_byte[TWM_WCOL_BIT] = st_r.wcol;
    ctrl_byte[TWM_EN_BIT]   = st_r.en;
    ctrl_byte[TWM_IE_BIT]   = st_r.ie;
    st_nxt.rsp.pready  = apb_req.psel & apb_req.penable & ~st_r.rsp.pready;
    st_nxt.rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !st_r.rsp.pready) begin
      case (apb_req.paddr)
        TWM_CTRL_OFS:   st_nxt.rsp.prdata = 32'(ctrl_byte);
        TWM_STATUS_OFS: st_nxt.rsp.prdata = 32'({st_r.code[7:3], 3'b000});
        TWM_DATA_OFS:   st_nxt.rsp.prdata = 32'(st_r.data);
        default: begin
          st_nxt.rsp.prdata  = 32'h0000_0000;
          st_nxt.rsp.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_ctrl) begin
      st_nxt.ack_en = w[TWM_ACK_BIT];
      st_nxt.sta    = w[TWM_STA_BIT];
      st_nxt.sto    = w[TWM_STO_BIT];
      st_nxt.en     = w[TWM_EN_BIT];
      st_nxt.ie     = w[TWM_IE_BIT];
      if (w[TWM_FLAG_BIT]) begin
        st_nxt.flag = 1'b0;
        go          = st_r.flag & w[TWM_EN_BIT];
      end
    end
    // the shift path owns the data register while the bus is moving
    if (wr_data) begin
      if (st_r.flag) begin
        st_nxt.data = w[7:0];
        st_nxt.wcol = 1'b0;
      end else begin
        st_nxt.wcol = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // bus sequencer; hardware flag sets come last so a set beats a clear
    // ----------------------------------------------------------------
    if (!st_nxt.en) begin
      st_nxt.fsm         = S_IDLE;
      st_nxt.pins.scl_oe = 1'b0;
      st_nxt.pins.sda_oe = 1'b0;
      st_nxt.cnt         = '0;
    end else begin
      case (st_r.fsm)
        S_IDLE: begin
          st_nxt.pins.scl_oe = 1'b0;
          st_nxt.pins.sda_oe = 1'b0;
          if (wr_ctrl && w[TWM_FLAG_BIT] && w[TWM_STA_BIT]) begin
            st_nxt.fsm = S_WAITFREE;
            st_nxt.cnt = '0;
            st_nxt.rep = 1'b0;
          end
        end
        S_WAITFREE: begin
          // someone else owns the bus: keep restarting the free-time count
          if (st_r.busy) begin
            st_nxt.cnt = '0;
          end else if (st_r.cnt == TWM_HALF_CYC) begin
            st_nxt.pins.sda_oe = 1'b1;
            st_nxt.fsm         = S_START;
            st_nxt.cnt         = '0;
          end else begin
            st_nxt.cnt = st_r.cnt + 9'h001;
          end
        end
        S_START: begin
          st_nxt.cnt = st_r.cnt + 9'h001;
          if (st_r.cnt == TWM_HALF_CYC) begin
            st_nxt.pins.scl_oe = 1'b1;
            st_nxt.flag        = 1'b1;
            st_nxt.code        = st_r.rep ? TWM_ST_RSTART : TWM_ST_START;
            st_nxt.addr_phase  = 1'b1;
            st_nxt.tx_mode     = 1'b0;
            st_nxt.fsm         = S_HOLD;
            st_nxt.cnt         = '0;
          end
        end
        S_HOLD: begin
          st_nxt.pins.scl_oe = 1'b1;
          st_nxt.pins.sda_oe = 1'b0;
          if (go) begin
            st_nxt.cnt   = '0;
            st_nxt.phase = 2'b00;
            if (w[TWM_STO_BIT]) begin
              st_nxt.fsm = S_STOP;
            end else if (w[TWM_STA_BIT]) begin
              st_nxt.fsm = S_RSTART;
            end else begin
              st_nxt.fsm      = S_LOW;
              st_nxt.bitn     = 4'h0;
              st_nxt.send_ack = w[TWM_ACK_BIT];
              if (tx) begin
                st_nxt.shift = st_r.data;
              end
            end
          end
        end
        S_LOW: begin
          st_nxt.pins.scl_oe = 1'b1;
          st_nxt.cnt         = st_r.cnt + 9'h001;
          // data changes two cycles after the clock went low (decided at count 1, registered on the next edge)
          if (st_r.cnt == 9'h001) begin
            if (st_r.bitn == TWM_ACK_BITN) begin
              st_nxt.bit_out = tx | ~st_r.send_ack;
            end else begin
              st_nxt.bit_out = tx ? st_r.shift[7] : 1'b1;
            end
            st_nxt.pins.sda_oe = ~st_nxt.bit_out;
          end
          if (st_r.cnt == TWM_HALF_CYC) begin
            st_nxt.pins.scl_oe = 1'b0;
            st_nxt.fsm         = S_HIGH;
            st_nxt.cnt         = '0;
          end
        end
        S_HIGH: begin
          // a slave stretching the clock holds the high-time count at zero
          if (!st_r.scl_sy[1]) begin
            st_nxt.cnt = '0;
          end else if (st_r.cnt != TWM_HALF_CYC) begin
            st_nxt.cnt = st_r.cnt + 9'h001;
          end else begin
            st_nxt.cnt         = '0;
            st_nxt.pins.scl_oe = 1'b1;
            lost = st_r.bit_out & ~s &
                   (tx ? (st_r.bitn != TWM_ACK_BITN) : (st_r.bitn == TWM_ACK_BITN));
            if (st_r.bitn != TWM_ACK_BITN) begin
              st_nxt.shift = {st_r.shift[6:0], s};
            end
            if (lost) begin
              st_nxt.fsm         = S_IDLE;
              st_nxt.pins.scl_oe = 1'b0;
              st_nxt.pins.sda_oe = 1'b0;
              st_nxt.flag        = 1'b1;
              st_nxt.code        = TWM_ST_LOST;
              st_nxt.addr_phase  = 1'b0;
              st_nxt.tx_mode     = 1'b0;
            end else if (st_r.bitn == TWM_ACK_BITN) begin
              st_nxt.fsm  = S_HOLD;
              st_nxt.flag = 1'b1;
              if (st_r.addr_phase) begin
                st_nxt.addr_phase = 1'b0;
                st_nxt.tx_mode    = ~st_r.data[0];
                if (st_r.data[0]) begin
                  st_nxt.code = s ? TWM_ST_RA_NAK : TWM_ST_RA_ACK;
                end else begin
                  st_nxt.code = s ? TWM_ST_WA_NAK : TWM_ST_WA_ACK;
                end
              end else if (st_r.tx_mode) begin
                st_nxt.code = s ? TWM_ST_TD_NAK : TWM_ST_TD_ACK;
              end else begin
                st_nxt.data = st_r.shift;
                st_nxt.code = st_r.send_ack ? TWM_ST_RD_ACK : TWM_ST_RD_NAK;
              end
            end else begin
              st_nxt.bitn = st_r.bitn + 4'h1;
              st_nxt.fsm  = S_LOW;
            end
          end
        end
        S_STOP: begin
          st_nxt.cnt = st_r.cnt + 9'h001;
          case (st_r.phase)
            2'b00: begin
              st_nxt.pins.scl_oe = 1'b1;
              if (st_r.cnt == 9'h001) begin
                st_nxt.pins.sda_oe = 1'b1;
              end
              if (st_r.cnt == TWM_HALF_CYC) begin
                st_nxt.pins.scl_oe = 1'b0;
                st_nxt.phase       = 2'b01;
                st_nxt.cnt         = '0;
              end
            end
            2'b01: begin
              if (!st_r.scl_sy[1]) begin
                st_nxt.cnt = '0;
              end else if (st_r.cnt == TWM_HALF_CYC) begin
                st_nxt.pins.sda_oe = 1'b0;
                st_nxt.phase       = 2'b10;
                st_nxt.cnt         = '0;
              end
            end
            default: begin
              if (st_r.cnt == TWM_HALF_CYC) begin
                st_nxt.sto        = 1'b0;
                st_nxt.addr_phase = 1'b0;
                st_nxt.tx_mode    = 1'b0;
                st_nxt.rep        = 1'b0;
                st_nxt.cnt        = '0;
                st_nxt.fsm        = st_r.sta ? S_WAITFREE : S_IDLE;
              end
            end
          endcase
        end
        S_RSTART: begin
          st_nxt.cnt = st_r.cnt + 9'h001;
          if (st_r.phase == 2'b00) begin
            st_nxt.pins.scl_oe = 1'b1;
            if (st_r.cnt == 9'h001) begin
              st_nxt.pins.sda_oe = 1'b0;
            end
            if (st_r.cnt == TWM_HALF_CYC) begin
              st_nxt.pins.scl_oe = 1'b0;
              st_nxt.phase       = 2'b01;
              st_nxt.cnt         = '0;
            end
          end else if (!st_r.scl_sy[1]) begin
            st_nxt.cnt = '0;
          end else if (st_r.cnt == TWM_HALF_CYC) begin
            st_nxt.pins.sda_oe = 1'b1;
            st_nxt.rep         = 1'b1;
            st_nxt.fsm         = S_START;
            st_nxt.cnt         = '0;
          end
        end
        default: begin
          st_nxt.fsm = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= TWM_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_enter_master;
    $rose(st_r.fsm == S_HOLD) |-> ($past(st_r.fsm) == S_START || $past(st_r.fsm) == S_HIGH);
  endproperty
  a_enter_master: assert property (p_enter_master) else $error("hold entered oddly");

  property p_code_low;
    st_r.en |-> st_r.code[2:0] == 3'b000;
  endproperty
  a_code_low: assert property (p_code_low) else $error("prescaler bits not zero");

  property p_off;
    (!st_r.en ##1 !st_r.en) |-> (st_r.fsm == S_IDLE && !st_r.pins.scl_oe && !st_r.pins.sda_oe);
  endproperty
  a_off: assert property (p_off) else $error("bus active while disabled");

  property p_free_wait;
    (st_r.fsm == S_WAITFREE && st_r.busy) |=> st_r.fsm != S_START;
  endproperty
  a_free_wait: assert property (p_free_wait) else $error("start on busy bus");

  property p_start_code;
    (st_r.fsm == S_START && st_nxt.fsm == S_HOLD) |=>
      st_r.flag && (st_r.code == TWM_ST_START || st_r.code == TWM_ST_RSTART);
  endproperty
  a_start_code: assert property (p_start_code) else $error("bad start status");

  property p_addr_code;
    (st_r.fsm == S_HIGH && st_nxt.fsm == S_HOLD && st_r.addr_phase && st_r.data[0]) |=>
      st_r.flag && (st_r.code == TWM_ST_RA_ACK || st_r.code == TWM_ST_RA_NAK) && !st_r.tx_mode;
  endproperty
  a_addr_code: assert property (p_addr_code) else $error("bad read address status");

  property p_stop_clr;
    (st_r.fsm == S_STOP && st_nxt.fsm != S_STOP && st_nxt.en) |=> !st_r.sto;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop request not cleared");

  property p_ack_drive;
    (st_r.fsm == S_HIGH && st_r.bitn == TWM_ACK_BITN && !st_r.addr_phase && !st_r.tx_mode)
      |-> st_r.pins.sda_oe == st_r.send_ack;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("wrong acknowledge level");

  property p_rx_code;
    (st_r.fsm == S_HIGH && st_nxt.fsm == S_HOLD && !st_r.addr_phase && !st_r.tx_mode) |=>
      st_r.flag && st_r.code == (st_r.send_ack ? TWM_ST_RD_ACK : TWM_ST_RD_NAK);
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("bad receive status");

  property p_hold_scl;
    st_r.fsm == S_HOLD |-> st_r.pins.scl_oe;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock released in hold");

  c_start:   cover property (st_r.fsm == S_START ##1 st_r.fsm == S_HOLD);
  c_rx_byte: cover property (st_r.flag && st_r.code == TWM_ST_RD_ACK);
  c_stop:    cover property (st_r.fsm == S_STOP ##1 st_r.fsm == S_IDLE);

endmodule

// ### design/twm_pkg.sv
package twm_pkg;

  // ----------------------------------------------------------------
  // register map and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] TWM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TWM_STATUS_OFS = 8'h04;
  localparam logic [7:0] TWM_DATA_OFS   = 8'h08;

  localparam int TWM_FLAG_BIT = 7;
  localparam int TWM_ACK_BIT  = 6;
  localparam int TWM_STA_BIT  = 5;
  localparam int TWM_STO_BIT  = 4;
  localparam int TWM_WCOL_BIT = 3;
  localparam int TWM_EN_BIT   = 2;
  localparam int TWM_IE_BIT   = 0;

  // ----------------------------------------------------------------
  // status codes, prescaler bits always zero
  // ----------------------------------------------------------------
  localparam logic [7:0] TWM_ST_START  = 8'h08;
  localparam logic [7:0] TWM_ST_RSTART = 8'h10;
  localparam logic [7:0] TWM_ST_WA_ACK = 8'h18;
  localparam logic [7:0] TWM_ST_WA_NAK = 8'h20;
  localparam logic [7:0] TWM_ST_TD_ACK = 8'h28;
  localparam logic [7:0] TWM_ST_TD_NAK = 8'h30;
  localparam logic [7:0] TWM_ST_LOST   = 8'h38;
  localparam logic [7:0] TWM_ST_RA_ACK = 8'h40;
  localparam logic [7:0] TWM_ST_RA_NAK = 8'h48;
  localparam logic [7:0] TWM_ST_RD_ACK = 8'h50;
  localparam logic [7:0] TWM_ST_RD_NAK = 8'h58;
  localparam logic [7:0] TWM_ST_NONE   = 8'hF8;
  localparam logic [7:0] TWM_DATA_RST  = 8'hFF;

  // ----------------------------------------------------------------
  // timing: half of a serial clock period
  // ----------------------------------------------------------------
  localparam int TWM_CLK_NS  = 25;
  localparam int TWM_HALF_NS = 5000;
  localparam logic [8:0] TWM_HALF_CYC =
    9'((TWM_HALF_NS + TWM_CLK_NS - 1) / TWM_CLK_NS);
  localparam logic [3:0] TWM_ACK_BITN = 4'h8;

  typedef enum logic [7:0] {
    S_IDLE     = 8'b0000_0001,
    S_WAITFREE = 8'b0000_0010,
    S_START    = 8'b0000_0100,
    S_HOLD     = 8'b0000_1000,
    S_LOW      = 8'b0001_0000,
    S_HIGH     = 8'b0010_0000,
    S_STOP     = 8'b0100_0000,
    S_RSTART   = 8'b1000_0000
  } twm_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } twm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } twm_apb_rsp_t;

  // open-drain pins: the data outputs stay low, the enables pull
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twm_pins_t;

  typedef struct packed {
    twm_fsm_t     fsm;
    logic [1:0]   phase;
    logic [8:0]   cnt;
    logic [3:0]   bitn;
    logic [7:0]   shift;
    logic         flag;
    logic         ack_en;
    logic         sta;
    logic         sto;
    logic         wcol;
    logic         en;
    logic         ie;
    logic [7:0]   code;
    logic [7:0]   data;
    logic         tx_mode;
    logic         addr_phase;
    logic         send_ack;
    logic         bit_out;
    logic         rep;
    logic         busy;
    logic [1:0]   sda_sy;
    logic [1:0]   scl_sy;
    logic         sda_q;
    logic         scl_q;
    twm_pins_t    pins;
    twm_apb_rsp_t rsp;
  } twm_state_t;

  localparam twm_state_t TWM_STATE_RST = '{
    fsm: S_IDLE, code: TWM_ST_NONE, data: TWM_DATA_RST,
    sda_sy: 2'b11, scl_sy: 2'b11, sda_q: 1'b1, scl_q: 1'b1, default: '0};

endpackage

// ### test/twm_slave_model.sv
`timescale 1ns/1ps
module twm_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] DATA0 = 8'hC5
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      sda_oe,
  output logic      scl_oe,
  output logic      last_ack
);
  logic [7:0] sh;
  logic [7:0] tx;
  event       go;

  initial begin
    sda_oe   = 1'b0;
    scl_oe   = 1'b0;
    last_ack = 1'b1;
  end

  // ----------------------------------------------------------------
  // start and stop abort any frame in progress
  // ----------------------------------------------------------------
  always @(negedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    // let the aborted frame block return to its wait before the new frame starts
    #0 -> go;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end

  // lines change 300 ns after scl falls so they never move while it is high
  always @(go) begin : xfer
    repeat (8) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
    @(negedge scl) #300;
    if (sh[7:1] == ADDR) begin
      sda_oe = 1'b1;
      @(negedge scl) #300;
      sda_oe = 1'b0;
      tx = DATA0;
      if (sh[0]) do begin
        // first bit settles before a stretch ends, so sda never moves with scl high
        sda_oe = ~tx[7];
        // slow answer: stretch the low phase beyond the master's own count
        if (slow) begin
          scl_oe = 1'b1;
          #20000 scl_oe = 1'b0;
        end
        for (int i = 7; i >= 0; i--) begin
          sda_oe = ~tx[i];
          @(negedge scl) #300;
        end
        sda_oe = 1'b0;
        @(posedge scl) last_ack = sda;
        @(negedge scl) #300;
        tx = tx + 8'h01;
      end while (last_ack === 1'b0);
    end
  end
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  import twm_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [6:0] SLV = 7'h2A;

  logic         core_clk;
  logic         reset;
  twm_apb_req_t req;
  twm_apb_rsp_t rsp;
  twm_pins_t    pins;
  logic         s_sda_oe;
  logic         s_scl_oe;
  logic         last_ack;
  logic         slow;
  logic         hog;
  logic [31:0]  rdat;
  logic         perr;
  int           n_errors;
  int           n_compared;
  // open drain with pull-ups: released by all means high; hog plays a second master
  wire          scl_w = ~pins.scl_oe & ~s_scl_oe;
  wire          sda_w = ~pins.sda_oe & ~s_sda_oe & ~hog;

  twm_master_rx dut (
    .core_clk (core_clk),
    .reset    (reset),
    .apb_req  (req),
    .apb_rsp  (rsp),
    .scl_in   (scl_w),
    .sda_in   (sda_w),
    .bus_pins (pins)
  );

  twm_slave_model #(.ADDR(SLV), .DATA0(8'hC5)) slv (
    .scl      (scl_w),
    .sda      (sda_w),
    .slow     (slow),
    .sda_oe   (s_sda_oe),
    .scl_oe   (s_scl_oe),
    .last_ack (last_ack)
  );

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rdat = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
    if (k >= 20) begin
      n_errors++;
      wrap_up;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask

  task automatic wait_ctrl(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, TWM_CTRL_OFS, 8'h00);
      k++;
    end while (rdat[b] !== v && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      wrap_up;
    end
  endtask

  task automatic st(input logic [7:0] code);
    wait_ctrl(TWM_FLAG_BIT, 1'b1);
    rd(TWM_STATUS_OFS, {24'h00_0000, code});
    chk_pin(scl_w, 1'b0);
    chk_pin(pins.scl_o | pins.sda_o, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    req        = '0;
    reset      = 1'b1;
    slow       = 1'b0;
    hog        = 1'b0;
    n_errors   = 0;
    n_compared = 0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rd(TWM_CTRL_OFS, 32'h0000_0000);
    rd(TWM_STATUS_OFS, 32'h0000_00F8);
    rd(TWM_DATA_OFS, 32'h0000_00FF);
    rd(8'h0C, 32'h0000_0000);
    chk_pin(perr, 1'b1);
    wr(TWM_CTRL_OFS, 8'hA0);
    repeat (600) @(posedge core_clk);
    chk_pin(sda_w, 1'b1);
    rd(TWM_STATUS_OFS, 32'h0000_00F8);
    hog <= 1'b1;
    wr(TWM_CTRL_OFS, 8'hA4);
    repeat (600) @(posedge core_clk);
    rd(TWM_CTRL_OFS, 32'h0000_0024);
    chk_pin(scl_w, 1'b1);
    hog <= 1'b0;
    st(TWM_ST_START);
    slow <= 1'b1;
    wr(TWM_DATA_OFS, {SLV, 1'b1});
    wr(TWM_CTRL_OFS, 8'hC4);
    st(TWM_ST_RA_ACK);
    wr(TWM_CTRL_OFS, 8'hC4);
    st(TWM_ST_RD_ACK);
    rd(TWM_DATA_OFS, 32'h0000_00C5);
    chk_pin(last_ack, 1'b0);
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_RD_NAK);
    slow <= 1'b0;
    rd(TWM_DATA_OFS, 32'h0000_00C6);
    chk_pin(last_ack, 1'b1);
    wr(TWM_CTRL_OFS, 8'hA4);
    st(TWM_ST_RSTART);
    wr(TWM_DATA_OFS, {SLV, 1'b1});
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_RA_ACK);
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_RD_NAK);
    rd(TWM_DATA_OFS, 32'h0000_00C5);
    wr(TWM_CTRL_OFS, 8'hB4);
    st(TWM_ST_START);
    wr(TWM_DATA_OFS, {~SLV, 1'b1});
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_RA_NAK);
    wr(TWM_CTRL_OFS, 8'hA4);
    st(TWM_ST_RSTART);
    wr(TWM_DATA_OFS, {~SLV, 1'b0});
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_WA_NAK);
    wr(TWM_CTRL_OFS, 8'hA4);
    st(TWM_ST_RSTART);
    wr(TWM_DATA_OFS, {~SLV, 1'b1});
    wr(TWM_CTRL_OFS, 8'h84);
    st(TWM_ST_RA_NAK);
    wr(TWM_CTRL_OFS, 8'h94);
    wait_ctrl(TWM_STO_BIT, 1'b0);
    rd(TWM_CTRL_OFS, 32'h0000_0004);
    chk_pin(scl_w, 1'b1);
    chk_pin(sda_w, 1'b1);
    wrap_up;
  end
endmodule
